/* File: verilog/sprr_defs.svh */
// Constants for the serial port role routing block
`ifndef SPRR_DEFS_SVH
`define SPRR_DEFS_SVH
`define SPRR_COMM_REG_OFFSET 3'h4
`define SPRR_BIT_TX_CLK_EN   2
`define SPRR_BIT_RX_CLK_EN   3
`define SPRR_BIT_REMOTE_LOOP 4
`define SPRR_BIT_LOCAL_LOOP  5
`define SPRR_BIT_TEST_STATUS 7
`define SPRR_COMM_RESET      8'h00
`define SPRR_IRQ_SEL_TEST    2'h3
`endif

/* File: verilog/sprr_pkg.sv */
// Types for the serial port role routing block
package sprr_pkg;
  typedef enum logic [1:0] {
    SPRR_ROLE_TERMINAL = 2'b01,
    SPRR_ROLE_COMM     = 2'b10
  } sprr_role_t;
endpackage : sprr_pkg

/* File: verilog/sprr_sync.sv */
// Two-flop synchroniser for pin inputs
module sprr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : sprr_sync

/* File: verilog/sprr_routing.sv */
// Serial port role routing between controller, register and connector
// Behaviour
// - A static strap picks the terminal or communication role, which sets signal meaning, pins and clock options.
// - Terminal role drives RTS and DTR and receives CD, CTS on channel A and DSR on the channel B carrier input.
// - Terminal role drives the transmit clock out from channel A's clock pin when its enable bit is set, else takes it in.
// - Terminal role treats the receive clock enable as clear and always takes the receive clock in.
// - Local loopback output follows register bit D5 and remote loopback follows bit D4.
// - Asserted test mode can raise an interrupt and reads as register bit D7.
// - Communication role drives CTS, CD and DSR and receives DTR and RTS, with CD from channel B's request output.
// - Communication role drives the receive clock from channel B's clock pin when its enable is set, else takes it in.
// - Communication role treats the transmit clock enable as set and always drives the transmit clock out.
// - Communication role swaps drive and receive connector positions so a straight cable joins the two roles.
// - Test signals behave the same in both roles.
// - The communications register sits at offset four from the card base.
// - The test mode interrupt reaches the host only when the interrupt source field selects test mode.
// - Writes to the receive clock enable do nothing in terminal role and to the transmit enable in communication role.
`include "sprr_defs.svh"
module sprr_routing (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               role_comm_strap,
  input  wire logic [2:0]         reg_addr,
  input  wire logic               reg_write,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  input  wire logic               irq_source_hi,
  input  wire logic               irq_source_lo,
  // Controller side
  input  wire logic               chan_a_rts_out,
  input  wire logic               chan_a_ready_req_out,
  input  wire logic               chan_b_ready_req_out,
  input  wire logic               chan_a_tx_data,
  output logic                    chan_a_rx_data,
  output logic                    chan_a_cts_in,
  output logic                    chan_a_carrier_in,
  output logic                    chan_b_carrier_in,
  input  wire logic               chan_a_clock_pin_o,
  output logic                    chan_a_clock_pin_i,
  input  wire logic               chan_b_clock_pin_o,
  output logic                    rx_clock_inputs,
  // Connector side, each position as input, output and enable
  input  wire logic               conn_pin2_i,
  output logic                    conn_pin2_o,
  output logic                    conn_pin2_oe,
  input  wire logic               conn_pin3_i,
  output logic                    conn_pin3_o,
  output logic                    conn_pin3_oe,
  input  wire logic               conn_pin4_i,
  output logic                    conn_pin4_o,
  output logic                    conn_pin4_oe,
  input  wire logic               conn_pin5_i,
  output logic                    conn_pin5_o,
  output logic                    conn_pin5_oe,
  input  wire logic               conn_pin6_i,
  output logic                    conn_pin6_o,
  output logic                    conn_pin6_oe,
  input  wire logic               conn_pin8_i,
  output logic                    conn_pin8_o,
  output logic                    conn_pin8_oe,
  input  wire logic               conn_pin20_i,
  output logic                    conn_pin20_o,
  output logic                    conn_pin20_oe,
  input  wire logic               tx_element_clock_i,
  output logic                    tx_element_clock_o,
  output logic                    tx_element_clock_oe,
  input  wire logic               rx_element_clock_i,
  output logic                    rx_element_clock_o,
  output logic                    rx_element_clock_oe,
  output logic                    local_loop_out,
  output logic                    remote_loop_out,
  input  wire logic               test_mode_in,
  output logic                    test_mode_irq,
  output sprr_pkg::sprr_role_t    role
);
  import sprr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic       strapSync;
  logic [9:0] pinSync;
  logic       modeSync;
  logic       pin2S, pin3S, pin4S, pin5S, pin6S, pin8S, pin20S, txClkS, rxClkS;

  sprr_sync #(.WIDTH(1)) u_strap (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (role_comm_strap),
    .dout    (strapSync)
  );
  sprr_sync #(.WIDTH(10)) u_pins (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     ({test_mode_in, rx_element_clock_i, tx_element_clock_i, conn_pin20_i, conn_pin8_i,
               conn_pin6_i, conn_pin5_i, conn_pin4_i, conn_pin3_i, conn_pin2_i}),
    .dout    (pinSync)
  );
  assign {modeSync, rxClkS, txClkS, pin20S, pin8S, pin6S, pin5S, pin4S, pin3S, pin2S} = pinSync;

  ////////////////////////////////////////////////////////////////////////////
  // Role and communications register
  sprr_role_t next_role;
  logic       isComm;
  logic       localLoop, remoteLoop, txClkEn, rxClkEn;
  logic       next_localLoop, next_remoteLoop, next_txClkEn, next_rxClkEn;
  logic       regHit;

  assign isComm = (role == SPRR_ROLE_COMM);
  assign regHit = reg_write && (reg_addr == `SPRR_COMM_REG_OFFSET);

  always_comb begin
    next_role       = strapSync ? SPRR_ROLE_COMM : SPRR_ROLE_TERMINAL;
    next_localLoop  = localLoop;
    next_remoteLoop = remoteLoop;
    next_txClkEn    = txClkEn;
    next_rxClkEn    = rxClkEn;
    if (regHit) begin
      next_localLoop  = reg_wdata[`SPRR_BIT_LOCAL_LOOP];
      next_remoteLoop = reg_wdata[`SPRR_BIT_REMOTE_LOOP];
      next_txClkEn    = reg_wdata[`SPRR_BIT_TX_CLK_EN];
      next_rxClkEn    = reg_wdata[`SPRR_BIT_RX_CLK_EN];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      role       <= SPRR_ROLE_TERMINAL;
      localLoop  <= 1'b0;
      remoteLoop <= 1'b0;
      txClkEn    <= 1'b0;
      rxClkEn    <= 1'b0;
    end else begin
      role       <= next_role;
      localLoop  <= next_localLoop;
      remoteLoop <= next_remoteLoop;
      txClkEn    <= next_txClkEn;
      rxClkEn    <= next_rxClkEn;
    end
  end

  // Effective enables after role forcing
  logic effTx, effRx;
  assign effTx = isComm ? 1'b1 : txClkEn;
  assign effRx = isComm ? rxClkEn : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Registered routing
  logic [7:0] next_rdata;
  logic next_rxData, next_cts, next_carA, next_carB, next_clkA, next_rxIn;
  logic next_p2, next_p2e, next_p3, next_p3e, next_p4, next_p4e, next_p5, next_p5e;
  logic next_p6, next_p6e, next_p8, next_p8e, next_p20, next_p20e;
  logic next_tco, next_tcoe, next_rco, next_rcoe, next_irq;

  always_comb begin
    next_rdata = 8'h00;
    next_rdata[`SPRR_BIT_TEST_STATUS] = modeSync;
    next_rdata[`SPRR_BIT_LOCAL_LOOP]  = localLoop;
    next_rdata[`SPRR_BIT_REMOTE_LOOP] = remoteLoop;
    next_rdata[`SPRR_BIT_RX_CLK_EN]   = effRx;
    next_rdata[`SPRR_BIT_TX_CLK_EN]   = effTx;
    next_irq  = modeSync && ({irq_source_hi, irq_source_lo} == `SPRR_IRQ_SEL_TEST);
    next_p2   = chan_a_tx_data;
    next_p2e  = 1'b1;
    next_p3   = 1'b0;
    next_p3e  = 1'b0;
    next_rxData = pin3S;
    if (isComm) begin
      next_p2e    = 1'b0;
      next_p3     = chan_a_tx_data;
      next_p3e    = 1'b1;
      next_rxData = pin2S;
      next_p4  = 1'b0;
      next_p4e = 1'b0;
      next_cts = pin4S;
      next_p5  = chan_a_rts_out;
      next_p5e = 1'b1;
      next_p6  = chan_a_ready_req_out;
      next_p6e = 1'b1;
      next_p8  = chan_b_ready_req_out;
      next_p8e = 1'b1;
      next_p20  = 1'b0;
      next_p20e = 1'b0;
      next_carA = pin20S;
      next_carB = 1'b0;
    end else begin
      next_p4  = chan_a_rts_out;
      next_p4e = 1'b1;
      next_cts = pin5S;
      next_p5  = 1'b0;
      next_p5e = 1'b0;
      next_p6  = 1'b0;
      next_p6e = 1'b0;
      next_carB = pin6S;
      next_p8  = 1'b0;
      next_p8e = 1'b0;
      next_carA = pin8S;
      next_p20  = chan_a_ready_req_out;
      next_p20e = 1'b1;
    end
    // Transmit element clock on channel A clock pin
    next_tco  = chan_a_clock_pin_o;
    next_tcoe = effTx;
    next_clkA = effTx ? 1'b0 : txClkS;
    // Receive element clock from channel B clock pin
    next_rco  = chan_b_clock_pin_o;
    next_rcoe = effRx;
    next_rxIn = effRx ? chan_b_clock_pin_o : rxClkS;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata           <= `SPRR_COMM_RESET;
      test_mode_irq       <= 1'b0;
      local_loop_out      <= 1'b0;
      remote_loop_out     <= 1'b0;
      chan_a_rx_data      <= 1'b0;
      chan_a_cts_in       <= 1'b0;
      chan_a_carrier_in   <= 1'b0;
      chan_b_carrier_in   <= 1'b0;
      chan_a_clock_pin_i  <= 1'b0;
      rx_clock_inputs     <= 1'b0;
      conn_pin2_o  <= 1'b0;  conn_pin2_oe  <= 1'b0;
      conn_pin3_o  <= 1'b0;  conn_pin3_oe  <= 1'b0;
      conn_pin4_o  <= 1'b0;  conn_pin4_oe  <= 1'b0;
      conn_pin5_o  <= 1'b0;  conn_pin5_oe  <= 1'b0;
      conn_pin6_o  <= 1'b0;  conn_pin6_oe  <= 1'b0;
      conn_pin8_o  <= 1'b0;  conn_pin8_oe  <= 1'b0;
      conn_pin20_o <= 1'b0;  conn_pin20_oe <= 1'b0;
      tx_element_clock_o  <= 1'b0;
      tx_element_clock_oe <= 1'b0;
      rx_element_clock_o  <= 1'b0;
      rx_element_clock_oe <= 1'b0;
    end else begin
      reg_rdata           <= next_rdata;
      test_mode_irq       <= next_irq;
      local_loop_out      <= localLoop;
      remote_loop_out     <= remoteLoop;
      chan_a_rx_data      <= next_rxData;
      chan_a_cts_in       <= next_cts;
      chan_a_carrier_in   <= next_carA;
      chan_b_carrier_in   <= next_carB;
      chan_a_clock_pin_i  <= next_clkA;
      rx_clock_inputs     <= next_rxIn;
      conn_pin2_o  <= next_p2;   conn_pin2_oe  <= next_p2e;
      conn_pin3_o  <= next_p3;   conn_pin3_oe  <= next_p3e;
      conn_pin4_o  <= next_p4;   conn_pin4_oe  <= next_p4e;
      conn_pin5_o  <= next_p5;   conn_pin5_oe  <= next_p5e;
      conn_pin6_o  <= next_p6;   conn_pin6_oe  <= next_p6e;
      conn_pin8_o  <= next_p8;   conn_pin8_oe  <= next_p8e;
      conn_pin20_o <= next_p20;  conn_pin20_oe <= next_p20e;
      tx_element_clock_o  <= next_tco;
      tx_element_clock_oe <= next_tcoe;
      rx_element_clock_o  <= next_rco;
      rx_element_clock_oe <= next_rcoe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_term_rx_clk_in;
    @(posedge clk_sys) disable iff (reset)
      (role == SPRR_ROLE_TERMINAL && $past(role) == SPRR_ROLE_TERMINAL) |=> !rx_element_clock_oe;
  endproperty
  a_term_rx_clk_in: assert property (p_term_rx_clk_in) else $error("rx clock driven in terminal role");

  property p_comm_tx_clk_out;
    @(posedge clk_sys) disable iff (reset)
      (role == SPRR_ROLE_COMM) |=> tx_element_clock_oe;
  endproperty
  a_comm_tx_clk_out: assert property (p_comm_tx_clk_out) else $error("tx clock not driven in comm role");

  property p_term_tx_follow;
    @(posedge clk_sys) disable iff (reset)
      (role == SPRR_ROLE_TERMINAL && role == $past(role)) |=> (tx_element_clock_oe == $past(txClkEn));
  endproperty
  a_term_tx_follow: assert property (p_term_tx_follow) else $error("tx clock direction wrong");

  property p_comm_rx_follow;
    @(posedge clk_sys) disable iff (reset)
      (role == SPRR_ROLE_COMM) |=> (rx_element_clock_oe == $past(rxClkEn));
  endproperty
  a_comm_rx_follow: assert property (p_comm_rx_follow) else $error("rx clock direction wrong");

  property p_loop_write;
    @(posedge clk_sys) disable iff (reset)
      regHit |-> ##2 (local_loop_out == $past(reg_wdata[`SPRR_BIT_LOCAL_LOOP], 2))
        && (remote_loop_out == $past(reg_wdata[`SPRR_BIT_REMOTE_LOOP], 2));
  endproperty
  a_loop_write: assert property (p_loop_write) else $error("loop outputs do not follow write");

  property p_irq_gate;
    @(posedge clk_sys) disable iff (reset)
      test_mode_irq |-> ($past({irq_source_hi, irq_source_lo}) == `SPRR_IRQ_SEL_TEST) && $past(modeSync);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq raised without selection");

  property p_status_bit;
    @(posedge clk_sys) disable iff (reset)
      ##1 reg_rdata[`SPRR_BIT_TEST_STATUS] == $past(modeSync);
  endproperty
  a_status_bit: assert property (p_status_bit) else $error("test status bit wrong");

  property p_comm_swap;
    @(posedge clk_sys) disable iff (reset)
      (role == SPRR_ROLE_COMM) |=> conn_pin3_oe && !conn_pin2_oe && conn_pin8_oe && !conn_pin20_oe;
  endproperty
  a_comm_swap: assert property (p_comm_swap) else $error("comm role pins not swapped");

  property p_term_drive;
    @(posedge clk_sys) disable iff (reset)
      (role == SPRR_ROLE_TERMINAL) |=> conn_pin4_oe && conn_pin20_oe && !conn_pin6_oe;
  endproperty
  a_term_drive: assert property (p_term_drive) else $error("terminal role drive wrong");

  c_comm_role:   cover property (@(posedge clk_sys) role == SPRR_ROLE_COMM);
  c_irq:         cover property (@(posedge clk_sys) test_mode_irq);
  c_tx_clk_out:  cover property (@(posedge clk_sys) role == SPRR_ROLE_TERMINAL && tx_element_clock_oe);
  c_rx_clk_out:  cover property (@(posedge clk_sys) rx_element_clock_oe);
endmodule : sprr_routing

/* File: verif/sprr_peer.sv */
// Far-side model: modem or peer card on the serial connector
module sprr_peer (
  input  wire logic       farIsDte,
  input  wire logic       txClkDrv,
  input  wire logic       rxClkDrv,
  input  wire logic       clkRun,
  input  wire logic [6:0] lvl,
  output logic      [8:0] peerO,
  output logic      [8:0] peerOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic linkClk;
  ////////////////////////////////////////
  // Link clock of 80 ns, held low outside frames
  initial begin
    linkClk = 1'b0;
    #7;
    forever begin
      #40;
      linkClk = clkRun ? ~linkClk : 1'b0;
    end
  end
  ////////////////////////////////////////
  // Peer drives the positions that the card receives
  always_comb begin
    peerOe = {rxClkDrv, txClkDrv, farIsDte ? 7'b1000101 : 7'b0111010};
    peerO  = {linkClk, linkClk, lvl};
  end
endmodule : sprr_peer

/* File: verif/tb.sv */
// Self-checking bench for the serial port role routing block
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sprr_pkg::*;
  logic       clk_sys, reset, role_comm_strap, reg_write, irq_source_hi, irq_source_lo;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       chan_a_rts_out, chan_a_ready_req_out, chan_b_ready_req_out, chan_a_tx_data;
  logic       chan_a_rx_data, chan_a_cts_in, chan_a_carrier_in, chan_b_carrier_in;
  logic       chan_a_clock_pin_o, chan_a_clock_pin_i, chan_b_clock_pin_o, rx_clock_inputs;
  logic       local_loop_out, remote_loop_out, test_mode_in, test_mode_irq;
  logic       farIsDte, txClkDrv, rxClkDrv, clkRun;
  logic       floatPat = 1'b0;
  logic [6:0] lvl;
  logic [8:0] devO, devOe, peerO, peerOe, lineLvl;
  sprr_role_t role;
  int         n_mismatch, compares;
  // Loop values never set both loop bits at once
  logic [7:0] wv [5] = '{8'h20, 8'h10, 8'h08, 8'h0C, 8'h04};
  ////////////////////////////////////////
  // Wire level: card, else peer, else a pattern that changes every cycle
  assign lineLvl = (devOe & devO) | (~devOe & peerOe & peerO) | (~devOe & ~peerOe & {9{floatPat}});
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) floatPat <= ~floatPat;
  sprr_routing i_sprr_routing (
    .clk_sys, .reset, .role_comm_strap, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
    .irq_source_hi, .irq_source_lo, .chan_a_rts_out, .chan_a_ready_req_out,
    .chan_b_ready_req_out, .chan_a_tx_data, .chan_a_rx_data, .chan_a_cts_in,
    .chan_a_carrier_in, .chan_b_carrier_in, .chan_a_clock_pin_o, .chan_a_clock_pin_i,
    .chan_b_clock_pin_o, .rx_clock_inputs, .local_loop_out, .remote_loop_out,
    .test_mode_in, .test_mode_irq, .role,
    .conn_pin2_i(lineLvl[0]), .conn_pin2_o(devO[0]), .conn_pin2_oe(devOe[0]),
    .conn_pin3_i(lineLvl[1]), .conn_pin3_o(devO[1]), .conn_pin3_oe(devOe[1]),
    .conn_pin4_i(lineLvl[2]), .conn_pin4_o(devO[2]), .conn_pin4_oe(devOe[2]),
    .conn_pin5_i(lineLvl[3]), .conn_pin5_o(devO[3]), .conn_pin5_oe(devOe[3]),
    .conn_pin6_i(lineLvl[4]), .conn_pin6_o(devO[4]), .conn_pin6_oe(devOe[4]),
    .conn_pin8_i(lineLvl[5]), .conn_pin8_o(devO[5]), .conn_pin8_oe(devOe[5]),
    .conn_pin20_i(lineLvl[6]), .conn_pin20_o(devO[6]), .conn_pin20_oe(devOe[6]),
    .tx_element_clock_i(lineLvl[7]), .tx_element_clock_o(devO[7]),
    .tx_element_clock_oe(devOe[7]),
    .rx_element_clock_i(lineLvl[8]), .rx_element_clock_o(devO[8]),
    .rx_element_clock_oe(devOe[8])
  );
  sprr_peer i_sprr_peer (.farIsDte, .txClkDrv, .rxClkDrv, .clkRun, .lvl, .peerO, .peerOe);
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic peerCfg(input logic [3:0] c);
    @(posedge clk_sys);
    {farIsDte, txClkDrv, rxClkDrv, clkRun} <= c;
  endtask : peerCfg
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    cyc(2);
  endtask : wr
  task automatic chkReg(input logic [7:0] d, input logic comm);
    `CHK(reg_rdata, {2'b00, d[5:4], comm & d[3], comm | d[2], 2'b00})
    `CHK({local_loop_out, remote_loop_out}, d[5:4])
    `CHK(devOe[8:7], {comm & d[3], comm | d[2]})
  endtask : chkReg
  task automatic chkRoute(input logic [3:0] p, input logic comm);
    @(posedge clk_sys);
    {chan_a_tx_data, chan_a_rts_out, chan_a_ready_req_out, chan_b_ready_req_out} <= p;
    lvl <= {p[0], ~p[1], p[2], p[3], ~p[0], p[1], ~p[2]};
    cyc(3);
    if (comm) begin
      `CHK(devOe[6:0], 7'b0111010)
      `CHK({devO[1], devO[3], devO[4], devO[5]}, p)
      `CHK({chan_a_rx_data, chan_a_cts_in, chan_a_carrier_in}, {lvl[0], lvl[2], lvl[6]})
    end else begin
      `CHK(devOe[6:0], 7'b1000101)
      `CHK({devO[0], devO[2], devO[6]}, p[3:1])
      `CHK({chan_a_rx_data, chan_a_cts_in, chan_b_carrier_in, chan_a_carrier_in}, {lvl[1], lvl[3], lvl[4], lvl[5]})
    end
    `CHK(devOe & peerOe, 9'h000)
  endtask : chkRoute
  task automatic followClk(input logic useRx);
    logic lv;
    repeat (16) begin
      @(negedge clk_sys);
      lv = useRx ? lineLvl[8] : lineLvl[7];
      cyc(3);
      `CHK(useRx ? rx_clock_inputs : chan_a_clock_pin_i, lv)
    end
  endtask : followClk
  task automatic driveClk(input logic chkRx);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys);
      chan_a_clock_pin_o <= v[0];
      chan_b_clock_pin_o <= ~v[0];
      cyc(3);
      `CHK(devO[7], v[0])
      if (chkRx) `CHK({devO[8], rx_clock_inputs}, {2{~v[0]}})
    end
  endtask : driveClk
  task automatic chkIrq();
    for (int s = 0; s < 5; s++) begin
      @(posedge clk_sys);
      {irq_source_hi, irq_source_lo} <= (s == 4) ? 2'h3 : s[1:0];
      test_mode_in <= (s != 4);
      cyc(3);
      `CHK(test_mode_irq, (s == 3))
      `CHK(reg_rdata[7], (s != 4))
    end
  endtask : chkIrq
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  // Watchdog, well beyond the few hundred cycles the tests take
  initial begin
    #100us;
    n_mismatch++;
    finish_test();
  end
  initial begin
    {reset, role_comm_strap, reg_write, irq_source_hi, irq_source_lo, test_mode_in} = 6'h20;
    {reg_addr, reg_wdata, lvl} = '0;
    {chan_a_rts_out, chan_a_ready_req_out, chan_b_ready_req_out, chan_a_tx_data} = '0;
    {chan_a_clock_pin_o, chan_b_clock_pin_o, farIsDte, txClkDrv, rxClkDrv, clkRun} = '0;
    n_mismatch = 0;
    compares = 0;
    cyc(1);
    `CHK({reg_rdata, devOe, local_loop_out, remote_loop_out}, 19'h0)
    @(posedge clk_sys);
    reset <= 1'b0;
    cyc(3);
    `CHK({role, reg_rdata, devOe}, {SPRR_ROLE_TERMINAL, 8'h00, 9'h045})
    peerCfg(4'b0111);
    for (int i = 0; i < 16; i += 5) chkRoute(i[3:0], 1'b0);
    followClk(1'b0);
    followClk(1'b1);
    peerCfg(4'b0011);
    foreach (wv[i]) begin
      wr(3'h4, wv[i]);
      chkReg(wv[i], 1'b0);
    end
    wr(3'h5, 8'h20);
    chkReg(8'h04, 1'b0);
    driveClk(1'b0);
    chkIrq();
    wr(3'h4, 8'h00);
    @(posedge clk_sys);
    role_comm_strap <= 1'b1;
    peerCfg(4'b1011);
    for (int k = 0; k < 10 && role !== SPRR_ROLE_COMM; k++) cyc(1);
    cyc(3);
    `CHK(role, SPRR_ROLE_COMM)
    chkReg(8'h00, 1'b1);
    for (int i = 0; i < 16; i += 5) chkRoute(i[3:0], 1'b1);
    followClk(1'b1);
    driveClk(1'b0);
    peerCfg(4'b1000);
    wr(3'h4, 8'h08);
    chkReg(8'h08, 1'b1);
    driveClk(1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(3'h4, wv[i]);
      chkReg(wv[i], 1'b1);
    end
    chkIrq();
    @(posedge clk_sys);
    reset <= 1'b1;
    cyc(1);
    `CHK({role, reg_rdata, remote_loop_out, devOe}, 20'h40000)
    @(posedge clk_sys);
    reset <= 1'b0;
    cyc(4);
    `CHK({role, reg_rdata, devOe}, {SPRR_ROLE_COMM, 8'h04, 9'h0BA})
    finish_test();
  end
endmodule : tb
